// ===== include/cpms_pkg.sv
// Package with constants and types for the codec power mode sequencer
// Notes on behaviour
// RQ1: Power-on enters power-down, everything reset and unpowered.
// RQ2: Stay powered down while reset pin low.
// RQ3: Strap high at release: hardware mode, power-up.
// RQ4: Strap low at release: software mode, standby.
// RQ5: Outputs clamped until bit cleared, ramp 200 ms.
// RQ6: DAC audio suppressed for 2000 sample periods.
// RQ7: Host powers down 250 ms before removing supply.
// RQ8: Power may return anytime, no off interval.
// RQ9: Host sends zero data before clock changes.
// RQ10: Clock change forces DAC zero data.
// RQ11: Mute control low in init, reset, mute, power-down.
// RQ12: Hardware mode waits for master clock valid.
// RQ13: Reference ramp mutes serial and analog outputs.
// RQ14: Measure clock ratio over one frame before running.
// RQ15: Software mode powers up when bit written zero.
// RQ16: Host hardware sequence: clocks, release, then serial.
// RQ17: Host software sequence: load, clocks, clear bit.
// RQ18: Power-down waits for muting to complete.
// RQ19: Host mutes inputs before hardware-mode reset.
// RQ20: Synchronise reset, latch strap once at release.
package cpms_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned RAMP_MS = 200;
  localparam int unsigned RAMP_CYCLES = RAMP_MS * (CLK_HZ / 1000);
  localparam int unsigned DAC_HOLD_SAMPLES = 2000;
  localparam int unsigned RATIO_W = 12;
  localparam int unsigned SAMPLE_W = 12;

  typedef enum logic [0:0] {
    CPMS_MODE_SW,
    CPMS_MODE_HW
  } cpms_mode_t;

  typedef enum {
    CPMS_OFF,
    CPMS_STANDBY,
    CPMS_RAMP,
    CPMS_MEASURE,
    CPMS_WARMUP,
    CPMS_RUN,
    CPMS_MUTING
  } cpms_state_t;

  // Status bundle seen by the rest of the codec
  typedef struct packed {
    logic refs_powered;
    logic analog_clamp;
    logic adc_mute;
    logic dac_zero;
    logic running;
  } cpms_status_t;
endpackage

// ===== verilog/cpms_ratio_meter.sv
// Counts reference clock cycles over one frame clock period
`timescale 1ns/1ps
`default_nettype none
module cpms_ratio_meter
  import cpms_pkg::*;
#(
  parameter int unsigned WIDTH = RATIO_W
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic enable_in,
  input wire logic frame_rise_in,
  // Result
  output logic done_out,
  output logic [WIDTH-1:0] ratio_out
);
  // Refused at elaboration so a bad width never reaches silicon
  if (WIDTH < 2) begin : bad_width
    $error("cpms_ratio_meter: WIDTH too small");
  end

  logic armed;
  logic [WIDTH-1:0] count;

  // Count from one frame edge to the next; count saturates at all ones, where ratio_out (count plus one) wraps to zero
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      armed <= 1'b0;
      count <= '0;
      done_out <= 1'b0;
      ratio_out <= '0;
    end else if (!enable_in) begin
      armed <= 1'b0;
      count <= '0;
      done_out <= 1'b0;
    end else if (!done_out) begin
      if (frame_rise_in && !armed) begin
        armed <= 1'b1;
        count <= '0;
      end else if (frame_rise_in && armed) begin
        ratio_out <= count + WIDTH'(1); // [RQ14]
        done_out <= 1'b1;
      end else if (armed && count != '1) begin
        count <= count + WIDTH'(1);
      end
    end
  end
endmodule
`default_nettype wire

// ===== verilog/cpms_sequencer.sv
// Power-up, power-down and mode sequencer for the stereo codec
`timescale 1ns/1ps
`default_nettype none
module cpms_sequencer
  import cpms_pkg::*;
#(
  parameter int unsigned RAMP_COUNT = RAMP_CYCLES,
  parameter int unsigned DAC_HOLD = DAC_HOLD_SAMPLES
) (
  // Clock and power-on reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // Host-driven pins and controls
  input wire logic reset_pin_n_in,
  input wire logic adc_data_strap_in,
  input wire logic power_down_bit_in,
  input wire logic master_clock_valid_in,
  input wire logic frame_clock_in,
  input wire logic clock_change_in,
  input wire logic mute_request_in,
  input wire logic mute_done_in,
  // Status and controls
  output cpms_mode_t mode_out,
  output cpms_status_t status_out,
  output logic [RATIO_W-1:0] clock_ratio_out,
  output logic ext_mute_ctrl_n_out
);
  // Sample counter cannot reach a hold count beyond its width
  if (RAMP_COUNT < 1 || DAC_HOLD < 1 || DAC_HOLD >= (1 << SAMPLE_W)) begin : bad_timing
    $error("cpms_sequencer: bad timing parameter");
  end

  localparam int unsigned RAMP_W = $clog2(RAMP_COUNT + 1);

  logic rst_meta;
  logic rst_sync_n;
  logic pin_meta;
  logic pin_sync;
  logic pin_prev;
  logic frame_prev;
  logic frame_rise;
  logic release_edge;
  cpms_state_t state;
  cpms_state_t next_state;
  logic [RAMP_W-1:0] ramp_count;
  logic [SAMPLE_W-1:0] sample_count;
  logic meter_done;
  logic [RATIO_W-1:0] meter_ratio;

  // Power-on reset release through two flops
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Reset pin synchroniser; first flop feeds only the second
  always_ff @(posedge ref_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= reset_pin_n_in; // [RQ20]
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign release_edge = pin_sync && !pin_prev;

  // Strap caught once, on the clocked release of the reset pin
  always_ff @(posedge ref_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode_out <= CPMS_MODE_SW;
    end else if (release_edge) begin
      mode_out <= adc_data_strap_in ? CPMS_MODE_HW : CPMS_MODE_SW; // [RQ20] [RQ3] [RQ4]
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      frame_prev <= 1'b0;
    end else begin
      frame_prev <= frame_clock_in;
    end
  end

  assign frame_rise = frame_clock_in && !frame_prev;

  // Mode is taken from the strap directly on the release cycle
  always_comb begin
    next_state = state;
    unique case (state)
      CPMS_OFF: begin
        if (release_edge) begin
          next_state = adc_data_strap_in ? CPMS_RAMP : CPMS_STANDBY; // [RQ3] [RQ4]
        end
      end
      CPMS_STANDBY: begin
        if (!power_down_bit_in) begin
          next_state = CPMS_RAMP; // [RQ15]
        end
      end
      CPMS_RAMP: begin
        if (ramp_count == RAMP_W'(RAMP_COUNT)) begin
          next_state = CPMS_MEASURE; // [RQ5]
        end
      end
      CPMS_MEASURE: begin
        if (meter_done) begin
          next_state = CPMS_WARMUP; // [RQ14]
        end
      end
      CPMS_WARMUP: begin
        if (sample_count == SAMPLE_W'(DAC_HOLD)) begin
          next_state = CPMS_RUN; // [RQ6]
        end
      end
      CPMS_RUN: begin
        next_state = CPMS_RUN;
      end
      CPMS_MUTING: begin
        if (mute_done_in) begin
          next_state = CPMS_STANDBY; // [RQ18]
        end
      end
    endcase
    // Software power-down from ramp, measure, warm-up or run leaves via the muting state
    if (mode_out == CPMS_MODE_SW && power_down_bit_in && state != CPMS_OFF
        && state != CPMS_STANDBY && state != CPMS_MUTING) begin
      next_state = CPMS_MUTING; // [RQ18]
    end
    if (!pin_sync && state != CPMS_OFF) begin
      next_state = CPMS_OFF; // [RQ2] [RQ8]
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= CPMS_OFF; // [RQ1]
    end else begin
      state <= next_state;
    end
  end

  // Reference ramp; in hardware mode it waits for a valid master clock
  always_ff @(posedge ref_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ramp_count <= '0;
    end else if (state != CPMS_RAMP) begin
      ramp_count <= '0;
    end else if ((mode_out == CPMS_MODE_SW || master_clock_valid_in) // [RQ12]
                 && ramp_count != RAMP_W'(RAMP_COUNT)) begin
      ramp_count <= ramp_count + RAMP_W'(1); // [RQ5]
    end
  end

  // Sample periods counted on frame clock edges
  always_ff @(posedge ref_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sample_count <= '0;
    end else if (state != CPMS_WARMUP) begin
      sample_count <= '0;
    end else if (frame_rise && sample_count != SAMPLE_W'(DAC_HOLD)) begin
      sample_count <= sample_count + SAMPLE_W'(1); // [RQ6]
    end
  end

  cpms_ratio_meter #(
    .WIDTH(RATIO_W)
  ) u_meter (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_sync_n),
    .enable_in(state == CPMS_MEASURE),
    .frame_rise_in(frame_rise),
    .done_out(meter_done),
    .ratio_out(meter_ratio)
  );

  always_ff @(posedge ref_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      clock_ratio_out <= '0;
    end else if (meter_done) begin
      clock_ratio_out <= meter_ratio; // [RQ14]
    end
  end

  // Registered status; outputs are silent until running
  always_ff @(posedge ref_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      status_out <= '{refs_powered: 1'b0, analog_clamp: 1'b1, adc_mute: 1'b1,
                      dac_zero: 1'b1, running: 1'b0}; // [RQ1]
      ext_mute_ctrl_n_out <= 1'b0; // [RQ11]
    end else begin
      status_out.refs_powered <= next_state inside {CPMS_RAMP, CPMS_MEASURE,
                                                    CPMS_WARMUP, CPMS_RUN, CPMS_MUTING};
      status_out.analog_clamp <= next_state inside {CPMS_OFF, CPMS_STANDBY}; // [RQ5]
      status_out.adc_mute <= next_state != CPMS_RUN; // [RQ13]
      status_out.dac_zero <= next_state != CPMS_RUN || clock_change_in; // [RQ6] [RQ10]
      status_out.running <= next_state == CPMS_RUN;
      ext_mute_ctrl_n_out <= !(next_state != CPMS_RUN || mute_request_in
                               || power_down_bit_in && mode_out == CPMS_MODE_SW); // [RQ11]
    end
  end
endmodule
`default_nettype wire

// ===== verif/cpms_seq_asserts.sv
// Assertion checker for the codec power mode sequencer
`timescale 1ns/1ps
`default_nettype none
module cpms_seq_checker
  import cpms_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // Host inputs
  input wire logic reset_pin_n_in,
  input wire logic power_down_bit_in,
  input wire logic clock_change_in,
  input wire logic mute_request_in,
  input wire logic mute_done_in,
  // Outputs
  input wire cpms_mode_t mode_out,
  input wire cpms_status_t status_out,
  input wire logic ext_mute_ctrl_n_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  pin_off_a: assert property (!reset_pin_n_in [*4] |-> !ext_mute_ctrl_n_out && !status_out.running)
    else $error("pin low not off");
  ext_run_a: assert property (ext_mute_ctrl_n_out |-> status_out.running)
    else $error("ext mute released early");
  mute_req_a: assert property (mute_request_in [*2] |-> !ext_mute_ctrl_n_out)
    else $error("mute request ignored");
  pdn_mute_a: assert property ((mode_out == CPMS_MODE_SW && power_down_bit_in) [*2] |-> !ext_mute_ctrl_n_out)
    else $error("power down not muted");
  clk_zero_a: assert property (clock_change_in [*2] |-> status_out.dac_zero)
    else $error("clock change not zeroed");
  ramp_mute_a: assert property (!status_out.running |-> status_out.adc_mute && status_out.dac_zero)
    else $error("mute dropped before run");
  run_bias_a: assert property (status_out.running |-> status_out.refs_powered && !status_out.analog_clamp)
    else $error("run while clamped");
  hw_up_a: assert property ($rose(mode_out == CPMS_MODE_HW) |-> status_out.refs_powered)
    else $error("hardware mode not powering");
  strap_hold_a: assert property ((reset_pin_n_in && $past(nrst_in, 8)) [*6] |-> $stable(mode_out))
    else $error("mode changed without release");
  pdn_wait_a: assert property ((status_out.refs_powered && !mute_done_in && reset_pin_n_in) [*3] |=> status_out.refs_powered)
    else $error("powered down before mute done");
  run_c: cover property ($rose(status_out.running));
  hw_run_c: cover property (status_out.running && mode_out == CPMS_MODE_HW);
  chg_c: cover property (status_out.running && clock_change_in);
endmodule
bind cpms_sequencer cpms_seq_checker cpms_seq_checker_i (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
  .reset_pin_n_in(reset_pin_n_in), .power_down_bit_in(power_down_bit_in),
  .clock_change_in(clock_change_in), .mute_request_in(mute_request_in),
  .mute_done_in(mute_done_in), .mode_out(mode_out), .status_out(status_out),
  .ext_mute_ctrl_n_out(ext_mute_ctrl_n_out));
`default_nettype wire

// ===== verif/cpms_host_model.sv
// Host model: frame clock source and mute completion responder
`timescale 1ns/1ps
`default_nettype none
module cpms_host_model (
  // Clock
  input wire logic ref_clk_in,
  // Bench controls
  input wire logic frame_en_in,
  input wire logic [3:0] frame_half_in,
  input wire logic power_down_bit_in,
  // Toward the sequencer
  output logic frame_clock_out,
  output logic mute_done_out
);
  logic [3:0] fcnt = 4'h0;
  logic [2:0] mcnt = 3'h0;
  initial frame_clock_out = 1'b0;
  // Frame clock only after master clocks are up; stands low otherwise
  always @(posedge ref_clk_in) begin
    if (!frame_en_in) begin
      fcnt <= 4'h0;
      frame_clock_out <= 1'b0;
    end else if (fcnt == frame_half_in - 4'h1) begin
      fcnt <= 4'h0;
      frame_clock_out <= !frame_clock_out;
    end else begin
      fcnt <= fcnt + 4'h1;
    end
  end
  // Muting takes five cycles, so power-down must really wait
  always @(posedge ref_clk_in) begin
    if (!power_down_bit_in) begin
      mcnt <= 3'h0;
    end else if (mcnt != 3'h5) begin
      mcnt <= mcnt + 3'h1;
    end
  end
  assign mute_done_out = (mcnt == 3'h5);
endmodule
`default_nettype wire

// ===== verif/codec_power_mode_sequencer_bench.sv
// Self-checking bench for the codec power mode sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; $display("unexpected %s exp %0h got %0h", n, e, a); end end
module codec_power_mode_sequencer_bench;
  import cpms_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, pin = 1'b0, st = 1'b0, power_down_bit = 1'b1, mv = 1'b0;
  logic cc = 1'b0, mr = 1'b0, fe = 1'b0, fc, md, xm, run_q = 1'b0;
  logic [3:0] half = 4'h3;
  cpms_mode_t mode;
  cpms_status_t stat;
  logic [RATIO_W-1:0] ratio;
  logic [RATIO_W:0] exp_q[$], nxt;
  int error_cnt = 0, samples_checked = 0, cycles = 0;
  cpms_sequencer #(.RAMP_COUNT(20), .DAC_HOLD(4)) cpms_sequencer_i (.ref_clk_in(clk),
    .nrst_in(rst_n), .reset_pin_n_in(pin), .adc_data_strap_in(st), .power_down_bit_in(power_down_bit),
    .master_clock_valid_in(mv), .frame_clock_in(fc), .clock_change_in(cc),
    .mute_request_in(mr), .mute_done_in(md), .mode_out(mode), .status_out(stat),
    .clock_ratio_out(ratio), .ext_mute_ctrl_n_out(xm));
  cpms_host_model cpms_host_model_i (.ref_clk_in(clk), .frame_en_in(fe), .frame_half_in(half),
    .power_down_bit_in(power_down_bit), .frame_clock_out(fc), .mute_done_out(md));
  initial forever #50 clk = !clk;
  task automatic stop_test();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  // Each power-up completion consumes the oldest expected mode and ratio
  always @(posedge clk) begin
    run_q <= stat.running;
    if (stat.running === 1'b1 && run_q !== 1'b1) begin
      nxt = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
      `CHK("mode_ratio", nxt, {mode, ratio})
    end
  end
  initial begin
    void'($urandom(32'h7715));
    tick(5);
    rst_n <= 1'b1;
    tick(3);
    `CHK("reset_out", 7'h1C, {mode, stat, xm})
    for (int i = 0; i < 4; i++) begin
      st <= i[0];
      half <= 4'h3 + 4'($urandom % 6);
      tick(2);
      pin <= 1'b1;
      tick(30);
      `CHK("standby", {i[0], 1'b0}, {stat.refs_powered, stat.running})
      exp_q.push_back({cpms_mode_t'(i[0]), RATIO_W'(2 * half)});
      power_down_bit <= 1'b0;
      mv <= 1'b1;
      fe <= 1'b1;
      for (int k = 0; k < 400 && stat.running !== 1'b1; k++) tick(1);
      `CHK("running", 1'b1, stat.running)
      `CHK("run_flags", 4'h1, {stat.analog_clamp, stat.adc_mute, stat.dac_zero, xm})
      // Data path is idle here, so the clock change meets silent input
      cc <= 1'b1;
      tick(3);
      `CHK("dac_zero", 1'b1, stat.dac_zero)
      cc <= 1'b0;
      mr <= 1'b1;
      tick(3);
      `CHK("ext_mute", 1'b0, xm)
      mr <= 1'b0;
      tick(3);
      `CHK("ext_mute", 1'b1, xm)
      power_down_bit <= 1'b1;
      tick(3);
      `CHK("refs_mute", 1'b1, stat.refs_powered)
      tick(10);
      `CHK("refs_down", i[0], stat.refs_powered)
      pin <= 1'b0;
      fe <= 1'b0;
      mv <= 1'b0;
      tick(4);
      `CHK("pin_low", 3'h0, {stat.refs_powered, stat.running, xm})
    end
    tick(5);
    `CHK("queue_left", 0, exp_q.size())
    stop_test();
  end
endmodule
`default_nettype wire
